// File: hw/pcmsp_defs.svh
`ifndef PCMSP_DEFS_SVH
`define PCMSP_DEFS_SVH
// ----------------------------------------
// word layout and coding masks
// ----------------------------------------
`define PCMSP_MSB 3'h7
`define PCMSP_MU_MASK 8'h7F
`define PCMSP_A_MASK 8'h55
`define PCMSP_IDLE_CODE 8'h80
// ----------------------------------------
// slot positions, in bit periods from frame start
// ----------------------------------------
`define PCMSP_B1_POS 5'h00
`define PCMSP_IDL_B2_POS 5'h0A
`define PCMSP_GCI_B2_POS 5'h08
`define PCMSP_LAST_OFS 5'h07
// ----------------------------------------
// synchroniser lanes
// ----------------------------------------
`define PCMSP_SYN_CLK 0
`define PCMSP_SYN_FS 1
`define PCMSP_SYN_DAT 2
// ----------------------------------------
// timing: frame time and link clock divider
// ----------------------------------------
`define PCMSP_CLK_NS 100
`define PCMSP_FRAME_US 125
`define PCMSP_FRAME_CYC (`PCMSP_FRAME_US * 1000 / `PCMSP_CLK_NS)
`define PCMSP_HALF_CYC 4'h5
`define PCMSP_DIV_LAST 4'h9
`define PCMSP_PER_CYC (2 * 5)
`define PCMSP_PER_LAST 7'(`PCMSP_FRAME_CYC / `PCMSP_PER_CYC - 1)
`define PCMSP_SAMPLE_PH 4'h8
`endif

// File: hw/pcmsp_pkg.sv
package pcmsp_pkg;
    // ----------------------------------------
    // device frame states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PCMSP_ST_IDLE = 2'b01, // waiting for a frame start
        PCMSP_ST_FRAME = 2'b10 // counting bit periods
    } pcmsp_state_t;
endpackage : pcmsp_pkg

// File: hw/pcmsp_link_if.sv
`timescale 1ns/10ps
interface pcmsp_link_if;
    logic link_clock; // bit clock from controller
    logic link_sync; // frame sync from controller
    logic link_receive_line; // controller to device data
    logic link_transmit_line_o; // device data drive
    logic link_transmit_line_oe_n; // device enable, low drives
    logic link_transmit_line; // resolved line level
    // released line reads high, as through a pull-up
    assign link_transmit_line = link_transmit_line_oe_n ? 1'b1 : link_transmit_line_o;
    modport dev (
        input link_clock, link_sync, link_receive_line,
        output link_transmit_line_o, link_transmit_line_oe_n
    );
    modport ctl (
        output link_clock, link_sync, link_receive_line,
        input link_transmit_line
    );
endinterface : pcmsp_link_if

// File: hw/pcmsp_dev.sv
`timescale 1ns/10ps
`include "pcmsp_defs.svh"
// Operation
// - link mode: both words share one slot
// - controller syncs once per 125 us frame
// - GCI mode: both words share one slot
// - controller pulses FSC once per frame
// - link sync sampled on clock falling edge
// - receive bit captured on clock falling edge
// - drive and launch bits on rising edge
// - release transmit line after last falling edge
// - FSC sampled on DCL falling edge
// - Dout on first DCL rise, or FSC rise
// - next bits launched after DCL rising edge
// - release at second DCL fall in LSB
// - Din taken at DCL rising edge
// - word is sign, chord, step, MSB first
// - mu-law inverts all seven magnitude bits
// - A-law inverts even numbered bit positions
module pcmsp_dev
    import pcmsp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic law_mu,
    input wire logic mode_gci,
    input wire logic slot_b2,
    input wire logic [7:0] tx_code,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_code,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    pcmsp_link_if.dev link
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [2:0] syn1_r; // first synchroniser stage
    logic [2:0] syn2_r; // second synchroniser stage
    logic clk_d_r; // delayed link clock level
    logic fs_d_r; // delayed sync level
    logic lclk; // synchronised link clock
    logic lfs; // synchronised sync
    logic ldat; // synchronised receive data
    logic rise; // link clock rising edge
    logic fall; // link clock falling edge
    logic start; // frame start event
    logic launch; // bit launch event
    logic capture; // receive sample event
    logic bit_end; // end of a bit period
    logic abort; // frame dropped, sync lost
    pcmsp_state_t state_r; // frame state
    logic [4:0] pos_r; // bit period in frame
    logic half_r; // GCI: first rise of bit seen
    logic chk_r; // GCI: sync check pending
    logic [4:0] slot_pos; // first bit of our slot
    logic [4:0] last_pos; // last bit of our slot
    logic [2:0] idx; // bit number in slot
    logic in_slot; // current bit is ours
    logic is_last; // current bit is our LSB
    logic [7:0] mask; // law inversion mask
    logic [7:0] tx_word_r; // line word in flight
    logic [7:0] tx_hold_r; // user word held
    logic [7:0] tx_word_nxt; // coded word for this frame
    logic tx_hv_r; // hold valid
    logic tx_hv_nxt; // next hold valid
    logic tx_take; // user word accepted
    logic [6:0] rx_sh_r; // receive shifter
    logic push; // receive word complete
    logic [7:0] push_w; // decoded receive word
    logic pop; // user takes head
    logic [7:0] tail_r; // second buffer entry
    logic tail_v_r; // second entry valid

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    assign lclk = syn2_r[`PCMSP_SYN_CLK];
    assign lfs = syn2_r[`PCMSP_SYN_FS];
    assign ldat = syn2_r[`PCMSP_SYN_DAT];
    assign rise = lclk & ~clk_d_r;
    assign fall = ~lclk & clk_d_r;
    // link mode: sync taken at falling edge; GCI: FSC rise
    assign start = mode_gci ? (lfs & ~fs_d_r) : (fall & lfs);
    // GCI bits span two DCL cycles; link mode bits span one
    assign launch = mode_gci ? (rise & ~half_r) : rise;
    assign capture = mode_gci ? (rise & half_r) : fall;
    assign bit_end = mode_gci ? (fall & ~half_r) : fall;
    assign abort = chk_r & fall & ~lfs;

    // ----------------------------------------
    // slot selection, shared by both directions
    // ----------------------------------------
    always_comb begin
        if (!slot_b2) begin
            slot_pos = `PCMSP_B1_POS;
        end else if (mode_gci) begin
            slot_pos = `PCMSP_GCI_B2_POS;
        end else begin
            slot_pos = `PCMSP_IDL_B2_POS;
        end
    end
    assign last_pos = slot_pos + `PCMSP_LAST_OFS;
    assign idx = 3'(pos_r - slot_pos);
    assign in_slot = (state_r == PCMSP_ST_FRAME) && (pos_r >= slot_pos) && (pos_r <= last_pos);
    assign is_last = in_slot && (pos_r == last_pos);
    // inversion applies on encode and undone on decode
    assign mask = law_mu ? `PCMSP_MU_MASK : `PCMSP_A_MASK;

    // ----------------------------------------
    // synchronisers for the three link inputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syn1_r <= 3'h0;
            syn2_r <= 3'h0;
        end else begin
            syn1_r[`PCMSP_SYN_CLK] <= link.link_clock;
            syn1_r[`PCMSP_SYN_FS] <= link.link_sync;
            syn1_r[`PCMSP_SYN_DAT] <= link.link_receive_line;
            syn2_r <= syn1_r;
        end
    end

    // ----------------------------------------
    // edge detect history
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_d_r <= 1'b0;
            fs_d_r <= 1'b0;
        end else begin
            clk_d_r <= lclk;
            fs_d_r <= lfs;
        end
    end

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= PCMSP_ST_IDLE;
            pos_r <= 5'h00;
            half_r <= 1'b0;
            chk_r <= 1'b0;
        end else if (start) begin
            // every sync restarts the frame count
            state_r <= PCMSP_ST_FRAME;
            pos_r <= 5'h00;
            half_r <= mode_gci & lclk;
            chk_r <= mode_gci;
        end else begin
            case (state_r)
                PCMSP_ST_IDLE: begin
                    half_r <= 1'b0;
                    chk_r <= 1'b0;
                end
                PCMSP_ST_FRAME: begin
                    if (abort) begin
                        state_r <= PCMSP_ST_IDLE;
                    end else if (bit_end && pos_r == last_pos) begin
                        state_r <= PCMSP_ST_IDLE; // slot done for this frame
                    end else if (bit_end) begin
                        pos_r <= pos_r + 5'h01;
                    end
                    if (mode_gci && rise) begin
                        half_r <= ~half_r;
                    end
                    if (fall) begin
                        chk_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= PCMSP_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // transmit line driver
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.link_transmit_line_o <= 1'b1;
            link.link_transmit_line_oe_n <= 1'b1;
        end else if (start && mode_gci && lclk && slot_pos == `PCMSP_B1_POS) begin
            // DCL already high: drive from the FSC rise itself
            link.link_transmit_line_o <= tx_word_nxt[`PCMSP_MSB];
            link.link_transmit_line_oe_n <= 1'b0;
        end else if (abort || start) begin
            link.link_transmit_line_oe_n <= 1'b1;
        end else if (bit_end && is_last) begin
            link.link_transmit_line_oe_n <= 1'b1;
        end else if (launch && in_slot) begin
            link.link_transmit_line_o <= tx_word_r[`PCMSP_MSB - idx];
            link.link_transmit_line_oe_n <= 1'b0;
        end
    end

    // ----------------------------------------
    // transmit word: held user word, coded at frame start
    // ----------------------------------------
    assign tx_word_nxt = (tx_hv_r ? tx_hold_r : `PCMSP_IDLE_CODE) ^ mask;
    assign tx_take = tx_valid & tx_ready;
    always_comb begin
        tx_hv_nxt = tx_hv_r;
        if (start) begin
            tx_hv_nxt = 1'b0;
        end
        if (tx_take) begin
            tx_hv_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_word_r <= `PCMSP_IDLE_CODE;
            tx_hold_r <= `PCMSP_IDLE_CODE;
            tx_hv_r <= 1'b0;
            tx_ready <= 1'b0;
        end else begin
            if (start) begin
                tx_word_r <= tx_word_nxt;
            end
            if (tx_take) begin
                tx_hold_r <= tx_code;
            end
            tx_hv_r <= tx_hv_nxt;
            tx_ready <= ~tx_hv_nxt;
        end
    end

    // ----------------------------------------
    // receive shifter, MSB first
    // ----------------------------------------
    assign push = capture && is_last;
    assign push_w = {rx_sh_r, ldat} ^ mask;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_sh_r <= 7'h00;
        end else if (capture && in_slot) begin
            rx_sh_r <= {rx_sh_r[5:0], ldat};
        end
    end

    // ----------------------------------------
    // two-entry receive buffer; head drives the ports
    // ----------------------------------------
    assign pop = rx_valid & rx_ready;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_code <= 8'h00;
            rx_valid <= 1'b0;
            tail_r <= 8'h00;
            tail_v_r <= 1'b0;
            rx_overrun <= 1'b0;
        end else begin
            rx_overrun <= push & ~pop & tail_v_r; // word lost, buffer full
            case ({push, pop})
                2'b10: begin
                    if (!rx_valid) begin
                        rx_code <= push_w;
                        rx_valid <= 1'b1;
                    end else if (!tail_v_r) begin
                        tail_r <= push_w;
                        tail_v_r <= 1'b1;
                    end
                end
                2'b01: begin
                    if (tail_v_r) begin
                        rx_code <= tail_r;
                        tail_v_r <= 1'b0;
                    end else begin
                        rx_valid <= 1'b0;
                    end
                end
                2'b11: begin
                    if (tail_v_r) begin
                        rx_code <= tail_r;
                        tail_r <= push_w;
                    end else begin
                        rx_code <= push_w;
                    end
                end
                default: begin
                    rx_valid <= rx_valid;
                end
            endcase
        end
    end
endmodule : pcmsp_dev

// File: hw/pcmsp_ctl.sv
`timescale 1ns/10ps
`include "pcmsp_defs.svh"
module pcmsp_ctl
    import pcmsp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mode_gci,
    input wire logic slot_b2,
    input wire logic [7:0] dtx_code,
    input wire logic dtx_valid,
    output logic dtx_ready,
    output logic [7:0] drx_code,
    output logic drx_valid,
    pcmsp_link_if.ctl link
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [3:0] div_r; // phase within a link period
    logic [6:0] per_r; // link period within frame
    logic [6:0] pos; // bit period within frame, full width
    logic run_r; // first frame end passed
    logic [4:0] slot_pos; // first bit of the slot
    logic [2:0] idx; // bit number in slot
    logic in_slot; // current bit is in the slot
    logic bit_first; // first link period of a bit
    logic frame_end; // last link period of frame
    logic [1:0] din_s_r; // device line synchroniser
    logic [7:0] word_r; // word sent this frame
    logic [7:0] hold_r; // user word held
    logic hv_r; // hold valid
    logic hv_nxt; // next hold valid
    logic [6:0] sh_r; // receive shifter

    // ----------------------------------------
    // bit and slot decode
    // ----------------------------------------
    assign frame_end = (per_r == `PCMSP_PER_LAST);
    // kept at full width so the slot is not seen again later in the frame
    assign pos = mode_gci ? (per_r >> 1) : per_r;
    assign bit_first = ~mode_gci | ~per_r[0];
    always_comb begin
        if (!slot_b2) begin
            slot_pos = `PCMSP_B1_POS;
        end else if (mode_gci) begin
            slot_pos = `PCMSP_GCI_B2_POS;
        end else begin
            slot_pos = `PCMSP_IDL_B2_POS;
        end
    end
    assign idx = 3'(pos - {2'b00, slot_pos});
    assign in_slot = ~frame_end && pos >= {2'b00, slot_pos}
        && pos <= {2'b00, slot_pos + `PCMSP_LAST_OFS};

    // ----------------------------------------
    // clock divider and frame counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r <= 4'h0;
            per_r <= 7'h00;
        end else if (div_r == `PCMSP_DIV_LAST) begin
            div_r <= 4'h0;
            per_r <= frame_end ? 7'h00 : per_r + 7'h01;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // no short first frame: the tail of the sync waits for a frame end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
        end else if (frame_end) begin
            run_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // clock, sync and data towards the device
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.link_clock <= 1'b0;
            link.link_sync <= 1'b0;
            link.link_receive_line <= 1'b1;
        end else begin
            link.link_clock <= (div_r < `PCMSP_HALF_CYC);
            if (mode_gci) begin
                // FSC rises with the DCL fall before frame start and spans the next DCL fall
                link.link_sync <= (frame_end && div_r >= `PCMSP_HALF_CYC)
                    || (run_r && per_r == 7'h00 && div_r < `PCMSP_DIV_LAST);
            end else begin
                link.link_sync <= frame_end;
            end
            if (div_r == 4'h0 && bit_first) begin
                // held over the device's sampling edge
                link.link_receive_line <= in_slot ? word_r[`PCMSP_MSB - idx] : 1'b1;
            end
        end
    end

    // ----------------------------------------
    // user word to send, latched once per frame
    // ----------------------------------------
    always_comb begin
        hv_nxt = hv_r;
        if (frame_end && div_r == 4'h0) begin
            hv_nxt = 1'b0;
        end
        if (dtx_valid && dtx_ready) begin
            hv_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_r <= `PCMSP_IDLE_CODE;
            hold_r <= `PCMSP_IDLE_CODE;
            hv_r <= 1'b0;
            dtx_ready <= 1'b0;
        end else begin
            if (frame_end && div_r == 4'h0) begin
                word_r <= hv_r ? hold_r : `PCMSP_IDLE_CODE;
            end
            if (dtx_valid && dtx_ready) begin
                hold_r <= dtx_code;
            end
            hv_r <= hv_nxt;
            dtx_ready <= ~hv_nxt;
        end
    end

    // ----------------------------------------
    // device line: synchronise, sample late in bit
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            din_s_r <= 2'b11;
            sh_r <= 7'h00;
            drx_code <= 8'h00;
            drx_valid <= 1'b0;
        end else begin
            din_s_r <= {din_s_r[0], link.link_transmit_line};
            drx_valid <= 1'b0;
            if (div_r == `PCMSP_SAMPLE_PH && ~bit_first | ~mode_gci && in_slot) begin
                sh_r <= {sh_r[5:0], din_s_r[1]};
                if (idx == `PCMSP_MSB) begin
                    drx_code <= {sh_r, din_s_r[1]};
                    drx_valid <= 1'b1;
                end
            end
        end
    end
endmodule : pcmsp_ctl

// File: test/pcmsp_checker.sv
`timescale 1ns/10ps
module pcmsp_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clock,
    input wire logic link_sync,
    input wire logic link_receive_line,
    input wire logic link_transmit_line_o,
    input wire logic link_transmit_line_oe_n,
    input wire logic link_transmit_line
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [10:0] frame_cnt_r; // cycles since sync rose
    logic seen_r; // a sync rise was seen
    logic [7:0] drive_cnt_r; // cycles the line is driven
    // frame length counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_cnt_r <= 11'h000;
            seen_r <= 1'b0;
        end else if ($rose(link_sync)) begin
            frame_cnt_r <= 11'h000;
            seen_r <= 1'b1;
        end else begin
            frame_cnt_r <= frame_cnt_r + 11'h001;
        end
    end
    // drive length counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_cnt_r <= 8'h00;
        end else if (link_transmit_line_oe_n) begin
            drive_cnt_r <= 8'h00;
        end else begin
            drive_cnt_r <= drive_cnt_r + 8'h01;
        end
    end
    // ----------------------------------------
    // line timing
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_drive_on_rise: assert property (
        $fell(link_transmit_line_oe_n) |-> link_clock) else $error("drive began with clock low");
    a_release_clock_low: assert property (
        $rose(link_transmit_line_oe_n) |-> !link_clock) else $error("release with clock high");
    a_bit_on_rise: assert property (
        !link_transmit_line_oe_n && !$past(link_transmit_line_oe_n)
        && $changed(link_transmit_line_o) |-> link_clock) else $error("bit changed, clock low");
    a_drive_length: assert property (
        $rose(link_transmit_line_oe_n) |-> drive_cnt_r inside {[70:80], [150:160]})
        else $error("drive length wrong");
    a_frame_period: assert property (
        $rose(link_sync) && seen_r |-> frame_cnt_r == 11'h4E1) else $error("frame period wrong");
    a_sync_over_fall: assert property (
        $rose(link_sync) |-> ##[1:10] ($fell(link_clock) && link_sync))
        else $error("sync not held over clock fall");
    a_rx_on_edge: assert property (
        $changed(link_receive_line) |-> $changed(link_clock)) else $error("rx data off edge");
    a_tx_stable_fall: assert property (
        $fell(link_clock) && !link_transmit_line_oe_n |-> $stable(link_transmit_line_o))
        else $error("tx data moved at fall");
endmodule : pcmsp_checker

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
    import pcmsp_pkg::*;
    logic clk, arst_n, law_mu, mode_gci, slot_b2; // clock, reset, static selects
    logic [7:0] tx_code, dtx_code, rx_code, drx_code; // user words
    logic tx_valid, tx_ready, rx_valid, rx_ready, rx_overrun, dtx_valid, dtx_ready, drx_valid;
    int n_mismatch, tests_run, cyc; // counters
    logic [7:0] q_drx[$], q_rx[$]; // expected words in order
    logic [31:0] rs; // xorshift state
    logic [8:0] pend; // word taken for next frame
    bit run, armed, hold_tx, stall, ovr, sync_q, new_tx, new_dtx;
    pcmsp_link_if link();
    pcmsp_dev i_pcmsp_dev(.clk(clk), .arst_n(arst_n), .law_mu(law_mu), .mode_gci(mode_gci),
        .slot_b2(slot_b2), .tx_code(tx_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_code(rx_code), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
        .link(link.dev));
    pcmsp_ctl i_pcmsp_ctl(.clk(clk), .arst_n(arst_n), .mode_gci(mode_gci), .slot_b2(slot_b2),
        .dtx_code(dtx_code), .dtx_valid(dtx_valid), .dtx_ready(dtx_ready),
        .drx_code(drx_code), .drx_valid(drx_valid), .link(link.ctl));
    pcmsp_checker i_pcmsp_checker(.clk(clk), .arst_n(arst_n), .link_clock(link.link_clock),
        .link_sync(link.link_sync), .link_receive_line(link.link_receive_line),
        .link_transmit_line_o(link.link_transmit_line_o),
        .link_transmit_line_oe_n(link.link_transmit_line_oe_n),
        .link_transmit_line(link.link_transmit_line));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // law mask applied on the line
    function automatic logic [7:0] mask_f();
        return law_mu ? 8'h7F : 8'h55;
    endfunction : mask_f
    // next random byte
    function automatic logic [7:0] rnd8();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction : rnd8
    // word compare
    task automatic chk_w(string nm, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w
    // flag compare
    task automatic chk_f(string nm, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_f
    // verdict and end of run
    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // clock and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ----------------------------------------
    // reference model at each rising edge
    // ----------------------------------------
    always @(posedge clk) begin
        new_tx = 0;
        new_dtx = 0;
        if (arst_n) begin
            if (link.link_sync && !sync_q) begin
                // frame start: taken word, else idle code
                q_drx.push_back(pend[8] ? pend[7:0] : (8'h80 ^ mask_f()));
                pend = 9'h000;
                armed = 1;
            end
            if (tx_valid && tx_ready) begin
                pend = {1'b1, tx_code ^ mask_f()};
                new_tx = 1;
            end
            if (dtx_valid && dtx_ready) begin
                q_rx.push_back(dtx_code ^ mask_f());
                new_dtx = 1;
            end
            if (drx_valid && armed) chk_w("drx_code", q_drx.pop_front(), drx_code);
            if (rx_valid && rx_ready) chk_w("rx_code", q_rx.pop_front(), rx_code);
            if (rx_overrun) begin
                ovr = 1;
                if (q_rx.size() > 2) q_rx.delete(2);
            end
        end
        sync_q = link.link_sync;
    end
    // ----------------------------------------
    // stimulus at falling edge
    // ----------------------------------------
    always @(negedge clk) begin
        if (run) begin
            if (new_tx) tx_code = rnd8();
            // valid never rises while sync is high; the next word after a take can start then
            if (new_tx || !tx_valid) tx_valid = !hold_tx && (tx_valid || !link.link_sync);
            if (new_dtx) dtx_code = rnd8();
            dtx_valid = 1'b1;
            rx_ready = !stall && rnd8() > 8'h60;
        end
    end
    // ----------------------------------------
    // main sequence: every law, slot and mode
    // ----------------------------------------
    initial begin
        rs = 32'h1B;
        {arst_n, law_mu, mode_gci, slot_b2, tx_valid, dtx_valid, rx_ready} = 7'h00;
        {tx_code, dtx_code} = 16'h0000;
        for (int c = 0; c < 8; c++) begin
            run = 0;
            arst_n = 1'b0;
            {mode_gci, slot_b2, law_mu} = c[2:0];
            {tx_valid, dtx_valid, rx_ready} = 3'h0;
            q_drx.delete();
            q_rx.delete();
            {armed, ovr, hold_tx, stall, pend} = 0;
            repeat (20) @(negedge clk);
            arst_n = 1'b1;
            repeat (2) @(negedge clk);
            run = 1;
            repeat (1250) @(negedge clk);
            // idle words and a stalled receiver
            {hold_tx, stall} = 2'b11;
            repeat (3750) @(negedge clk);
            {hold_tx, stall} = 2'b00;
            repeat (2500) @(negedge clk);
            chk_f("rx_overrun", 1'b1, ovr);
        end
        finish_test();
    end
endmodule : tb
